// ---- rtl/od_cfg.svh ----
`ifndef OD_CFG_SVH
`define OD_CFG_SVH

// ----------------------------------------
// Geometry
// ----------------------------------------
`define OD_NUM_PORTS 8
`define OD_NUM_LINES 10
`define OD_SYNC_W 70

// ----------------------------------------
// Register word indices (byte offset is four times)
// ----------------------------------------
`define OD_IDX_CTRL 4'h0
`define OD_IDX_STATUS 4'h1
`define OD_IDX_MASK 4'h2
`define OD_IDX_STRAPS 4'h3
`define OD_IDX_PENDING 4'h4
`define OD_IDX_CUST_LO 4'h8

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define OD_CTRL_ROUTE_EN 0
`define OD_CUST_EN 0
`define OD_CTRL_RST 1'h1
`define OD_MASK_RST 8'h00
`define OD_FACTORY_BASE 16'h0280
`define OD_FACTORY_STEP 16'h0008
`define OD_IRQ_NONE 4'h0

`endif

// ---- rtl/od_pkg.sv ----
package od_pkg;

   // ----------------------------------------
   // Interrupt mode of a port group
   // ----------------------------------------
   typedef enum logic [1:0] {
      OD_MODE_NORMAL,
      OD_MODE_SHARED,
      OD_MODE_MASTER,
      OD_MODE_OPEN
   } od_irq_mode_t;

endpackage : od_pkg

// ---- rtl/od_irq_router.sv ----
`include "od_cfg.svh"

module od_irq_router (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Port side
   input wire logic [7:0] pend,
   input wire logic [31:0] sel_flat,
   input wire od_pkg::od_irq_mode_t mode_lo,
   input wire od_pkg::od_irq_mode_t mode_hi,
   input wire logic ext_pd,
   input wire logic route_en,
   // Host lines
   output logic [9:0] line_out,
   output logic [9:0] line_oe,
   output logic [1:0] pulldown_en
);

   // ----------------------------------------
   // Selector decode
   // ----------------------------------------
   function automatic logic od_sel_is(input logic [3:0] code, input int line);
      return code == 4'(line + 1);
   endfunction : od_sel_is

   logic [9:0] norm_sel;
   logic [9:0] norm_val;
   logic [9:0] shr_val;
   logic [9:0] oe_d;
   logic [9:0] out_d;
   logic pd_ok;
   logic [9:0] line_out_q;
   logic [9:0] line_oe_q;
   logic [1:0] pd_q;

   // Pull-down present on card or elsewhere on the bus
   assign pd_ok = ext_pd || mode_lo == od_pkg::OD_MODE_MASTER
                  || mode_hi == od_pkg::OD_MODE_MASTER;

   always_comb begin
      norm_sel = '0;
      norm_val = '0;
      shr_val = '0;
      for (int l = 0; l < `OD_NUM_LINES; l++) begin
         for (int p = 0; p < `OD_NUM_PORTS; p++) begin
            if (od_sel_is(sel_flat[p*4 +: 4], l)) begin
               if ((p < 4 ? mode_lo : mode_hi) == od_pkg::OD_MODE_NORMAL) begin
                  norm_sel[l] = 1'b1;
                  norm_val[l] = norm_val[l] | pend[p];
               end else if ((p < 4 ? mode_lo : mode_hi) != od_pkg::OD_MODE_OPEN) begin
                  shr_val[l] = shr_val[l] | pend[p];
               end
            end
         end
      end
   end

   // Normal lines driven both ways, shared lines only pulled high
   assign oe_d = route_en ? (norm_sel | (shr_val & {10{pd_ok}})) : 10'h000;
   assign out_d = (norm_val | shr_val) & oe_d;

   always_ff @(posedge mclk) begin
      if (reset) begin
         line_out_q <= 10'h000;
         line_oe_q <= 10'h000;
         pd_q <= 2'h0;
      end else begin
         line_out_q <= out_d;
         line_oe_q <= oe_d;
         pd_q <= {mode_hi == od_pkg::OD_MODE_MASTER, mode_lo == od_pkg::OD_MODE_MASTER};
      end
   end

   assign line_out = line_out_q;
   assign line_oe = line_oe_q;
   assign pulldown_en = pd_q;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);

   a_no_sel_quiet: assert property (sel_flat == 32'h0 |=> line_oe == 10'h000)
      else $error("line driven with no selection");
   a_shared_no_pd: assert property (
      (!pd_ok && mode_lo != od_pkg::OD_MODE_NORMAL && mode_hi != od_pkg::OD_MODE_NORMAL)
      |=> line_oe == 10'h000)
      else $error("shared line driven without pull-down");
   a_shared_drive: assert property (
      (route_en && pd_ok && mode_lo == od_pkg::OD_MODE_SHARED && sel_flat[3:0] == 4'h3
       && pend[0]) |=> line_oe[2] && line_out[2])
      else $error("shared pending port not driving its line");
   a_normal_route: assert property (
      (route_en && mode_hi == od_pkg::OD_MODE_NORMAL && sel_flat[31:28] == 4'hA)
      |=> line_oe[9] && line_out[9] == $past(pend[7]))
      else $error("normal port not routed to its line");
   c_shared_drive: cover property (pd_ok && |shr_val ##1 |line_oe);

endmodule : od_irq_router

// ---- rtl/od_decode_top.sv ----
// Functional notes
// - In switch mode the card answers one block of 64 consecutive host I/O addresses.
// - The block base sits on a 64-byte boundary, so address bits 5..0 are not compared.
// - Port n owns the eight addresses at base plus 8*(n-1), base+0 through base+56.
// - Each base switch gives one address bit: on (closed) is 0, off (open) is 1.
// - Seven switches give address bits 12..6, on,on,on,off,on,off,on selects 280-2BF.
// - Factory setup puts port 1 at 280 and later ports at eight-address steps.
// - With the custom decode option chosen, ports decode at programmed addresses.
// - Each port has its own selector routing its interrupt onto one host line.
// - A port may own its host line or share it with other ports on any card.
// - One mode selector covers ports 1-4 and a second covers ports 5-8.
// - A port with no line selected drives no host interrupt line.
// - In shared mode with no pull-down anywhere the ports cannot raise an interrupt.
//
// Added by the designer: the Avalon-MM slave port and the register addresses.
`include "od_cfg.svh"

module od_decode_top (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Avalon-MM slave
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Host expansion bus
   input wire logic [15:0] host_addr,
   input wire logic host_aen,
   // Configuration straps
   input wire logic [6:0] base_switch_on,
   input wire logic decode_source_select,
   input wire logic [1:0] low_group_irq_mode_select,
   input wire logic [1:0] high_group_irq_mode_select,
   input wire logic [3:0] first_port_irq_selector,
   input wire logic [3:0] second_port_irq_selector,
   input wire logic [3:0] third_port_irq_selector,
   input wire logic [3:0] fourth_port_irq_selector,
   input wire logic [3:0] fifth_port_irq_selector,
   input wire logic [3:0] sixth_port_irq_selector,
   input wire logic [3:0] seventh_port_irq_selector,
   input wire logic [3:0] eighth_port_irq_selector,
   input wire logic ext_pulldown_sense,
   // Serial port side
   input wire logic [7:0] uart_irq,
   output logic [7:0] port_cs,
   output logic [2:0] port_reg,
   // Host interrupt lines
   output logic [9:0] host_irq_out,
   output logic [9:0] host_irq_oe,
   output logic [1:0] group_pulldown_en,
   // Card interrupt
   output logic irq
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [7:0] od_onehot(input logic [2:0] idx);
      return 8'h01 << idx;
   endfunction : od_onehot

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   logic [`OD_SYNC_W-1:0] sync_raw;
   logic [`OD_SYNC_W-1:0] sync1_q;
   logic [`OD_SYNC_W-1:0] sync2_q;

   assign sync_raw = {
      host_addr,
      host_aen,
      base_switch_on,
      decode_source_select,
      low_group_irq_mode_select,
      high_group_irq_mode_select,
      eighth_port_irq_selector,
      seventh_port_irq_selector,
      sixth_port_irq_selector,
      fifth_port_irq_selector,
      fourth_port_irq_selector,
      third_port_irq_selector,
      second_port_irq_selector,
      first_port_irq_selector,
      ext_pulldown_sense,
      uart_irq
   };

   always_ff @(posedge mclk) begin
      if (reset) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= sync_raw;
         sync2_q <= sync1_q;
      end
   end

   logic [15:0] addr_s;
   logic aen_s;
   logic [6:0] sw_s;
   logic dsrc_s;
   logic [1:0] mode_lo_s;
   logic [1:0] mode_hi_s;
   logic [31:0] sel_s;
   logic ext_pd_s;
   logic [7:0] pend_s;

   assign addr_s = sync2_q[69:54];
   assign aen_s = sync2_q[53];
   assign sw_s = sync2_q[52:46];
   assign dsrc_s = sync2_q[45];
   assign mode_lo_s = sync2_q[44:43];
   assign mode_hi_s = sync2_q[42:41];
   assign sel_s = sync2_q[40:9];
   assign ext_pd_s = sync2_q[8];
   assign pend_s = sync2_q[7:0];

   // ----------------------------------------
   // Register state
   // ----------------------------------------
   logic ctrl_route_q;
   logic [7:0] status_q;
   logic [7:0] mask_q;
   logic [7:0] pend_prev_q;
   logic [15:0] cust_q [8];
   logic ack_q;
   logic [31:0] rdata_q;
   logic [7:0] port_cs_q;
   logic [2:0] port_reg_q;

   // ----------------------------------------
   // Host address decode
   // ----------------------------------------
   logic [9:0] sw_base;
   logic sw_hit;
   logic [7:0] sw_sel;
   logic [7:0] cust_hit;
   logic [7:0] cust_sel;
   logic [7:0] dec_sel;

   // Switch on reads as 0, off as 1; switch one is address bit 12
   assign sw_base = {3'b000, ~sw_s};
   assign sw_hit = addr_s[15:6] == sw_base;
   assign sw_sel = sw_hit ? od_onehot(addr_s[5:3]) : 8'h00;

   for (genvar n = 0; n < `OD_NUM_PORTS; n++) begin : g_cust
      assign cust_hit[n] = cust_q[n][`OD_CUST_EN] && addr_s[15:3] == cust_q[n][15:3];
   end

   // Lowest numbered port wins an overlap
   assign cust_sel = cust_hit & (~cust_hit + 8'h01);
   assign dec_sel = aen_s ? 8'h00 : (dsrc_s ? cust_sel : sw_sel);

   always_ff @(posedge mclk) begin
      if (reset) begin
         port_cs_q <= 8'h00;
         port_reg_q <= 3'h0;
      end else begin
         port_cs_q <= dec_sel;
         port_reg_q <= addr_s[2:0];
      end
   end

   assign port_cs = port_cs_q;
   assign port_reg = port_reg_q;

   // ----------------------------------------
   // Avalon-MM slave
   // ----------------------------------------
   logic bus_req;
   logic [3:0] widx;
   logic wr_en;
   logic wr_status;
   logic wr_mask;
   logic wr_ctrl;
   logic wr_cust;
   logic [31:0] straps_rd;
   logic [31:0] rd_mux;

   assign bus_req = avs_read | avs_write;
   assign widx = avs_address[5:2];
   assign wr_en = avs_write & ack_q;
   assign wr_ctrl = wr_en && widx == `OD_IDX_CTRL;
   assign wr_status = wr_en && widx == `OD_IDX_STATUS;
   assign wr_mask = wr_en && widx == `OD_IDX_MASK;
   assign wr_cust = wr_en && widx >= `OD_IDX_CUST_LO;
   assign avs_waitrequest = bus_req & ~ack_q;

   assign straps_rd = {1'b0, ext_pd_s, group_pulldown_en, 16'h0000,
                       mode_hi_s, mode_lo_s, dsrc_s, sw_s};
   assign rd_mux = widx >= `OD_IDX_CUST_LO ? {16'h0000, cust_q[widx[2:0]]} :
                   widx == `OD_IDX_CTRL ? {31'h0, ctrl_route_q} :
                   widx == `OD_IDX_STATUS ? {24'h000000, status_q} :
                   widx == `OD_IDX_MASK ? {24'h000000, mask_q} :
                   widx == `OD_IDX_STRAPS ? straps_rd :
                   widx == `OD_IDX_PENDING ? {sel_s[23:0], pend_s} : 32'h00000000;

   always_ff @(posedge mclk) begin
      if (reset) begin
         ack_q <= 1'b0;
         rdata_q <= 32'h00000000;
      end else begin
         ack_q <= bus_req & ~ack_q;
         if (avs_read && !ack_q) begin
            rdata_q <= rd_mux;
         end
      end
   end

   assign avs_readdata = rdata_q;

   // ----------------------------------------
   // Control and custom decode table
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (reset) begin
         ctrl_route_q <= `OD_CTRL_RST;
         mask_q <= `OD_MASK_RST;
         for (int n = 0; n < `OD_NUM_PORTS; n++) begin
            cust_q[n] <= 16'(`OD_FACTORY_BASE + `OD_FACTORY_STEP * n) | 16'h0001;
         end
      end else begin
         if (wr_ctrl) begin
            ctrl_route_q <= avs_writedata[`OD_CTRL_ROUTE_EN];
         end
         if (wr_mask) begin
            mask_q <= avs_writedata[7:0];
         end
         if (wr_cust) begin
            cust_q[widx[2:0]] <= {avs_writedata[15:3], 2'b00, avs_writedata[0]};
         end
      end
   end

   // ----------------------------------------
   // Interrupt status
   // ----------------------------------------
   logic [7:0] rise;
   logic [7:0] status_d;

   assign rise = pend_s & ~pend_prev_q;
   // Rising edge wins over a same-cycle clear
   assign status_d = (status_q & ~(wr_status ? avs_writedata[7:0] : 8'h00)) | rise;

   always_ff @(posedge mclk) begin
      if (reset) begin
         status_q <= 8'h00;
         pend_prev_q <= 8'h00;
      end else begin
         status_q <= status_d;
         pend_prev_q <= pend_s;
      end
   end

   assign irq = |(status_q & mask_q);

   // ----------------------------------------
   // Host interrupt routing
   // ----------------------------------------
   od_irq_router u_router (
      .mclk(mclk),
      .reset(reset),
      .pend(pend_s),
      .sel_flat(sel_s),
      .mode_lo(od_pkg::od_irq_mode_t'(mode_lo_s)),
      .mode_hi(od_pkg::od_irq_mode_t'(mode_hi_s)),
      .ext_pd(ext_pd_s),
      .route_en(ctrl_route_q),
      .line_out(host_irq_out),
      .line_oe(host_irq_oe),
      .pulldown_en(group_pulldown_en)
   );

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);

   a_block_hit: assert property (
      (!dsrc_s && !aen_s && addr_s[15:6] == sw_base) |=> $onehot(port_cs))
      else $error("switch block address not decoded");
   a_align_miss: assert property (
      (!dsrc_s && addr_s[15:6] != sw_base) |=> port_cs == 8'h00)
      else $error("address outside block decoded");
   a_port_window: assert property (
      (!dsrc_s && !aen_s && sw_hit)
      |=> port_cs == od_onehot($past(addr_s[5:3])) && port_reg == $past(addr_s[2:0]))
      else $error("wrong port window");
   a_switch_polarity: assert property (
      (!dsrc_s && addr_s[15:6] == {3'b000, sw_s}) |=> port_cs == 8'h00)
      else $error("switch polarity inverted");
   a_factory_first: assert property (
      (!dsrc_s && !aen_s && sw_s == 7'h75 && addr_s == 16'h0280) |=> port_cs == 8'h01)
      else $error("base 280 does not select port 1");
   a_factory_last: assert property (
      (!dsrc_s && !aen_s && sw_s == 7'h75 && addr_s == 16'h02BF)
      |=> port_cs == 8'h80 && port_reg == 3'h7)
      else $error("base 2BF does not select port 8");
   a_custom_hit: assert property (
      (dsrc_s && !aen_s && cust_hit[2:0] == 3'h0 && cust_hit[3]) |=> port_cs == 8'h08)
      else $error("custom address not decoded");
   a_status_set: assert property (
      (pend_s[0] && !pend_prev_q[0]) |=> status_q[0] ##0 (irq || !mask_q[0]))
      else $error("interrupt event lost");
   a_wait_once: assert property (
      (bus_req && !ack_q) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("waitrequest not released after one cycle");
   a_dma_quiet: assert property (
      aen_s |=> port_cs == 8'h00)
      else $error("port selected during address-enable cycle");
   a_custom_one: assert property (
      (dsrc_s && !aen_s && cust_hit != 8'h00) |=> $onehot(port_cs))
      else $error("custom decode selected more than one port");
   a_custom_miss: assert property (
      (dsrc_s && cust_hit == 8'h00) |=> port_cs == 8'h00)
      else $error("custom decode selected a port with no hit");
   a_status_sticky: assert property (
      !wr_status |=> (status_q & $past(status_q)) == $past(status_q))
      else $error("status bit lost without a clear");
   a_status_clear: assert property (
      (wr_status && avs_writedata[0] && !rise[0]) |=> !status_q[0])
      else $error("status bit not cleared by write of one");
   a_set_wins: assert property (
      (rise[1] && wr_status) |=> status_q[1])
      else $error("clear beat a same-cycle event");
   a_route_off: assert property (
      !ctrl_route_q |=> host_irq_oe == 10'h000)
      else $error("host line driven with routing off");
   a_master_pd: assert property (
      (mode_lo_s == 2'h2) |=> group_pulldown_en[0])
      else $error("master group gives no pull-down");
   a_read_mask: assert property (
      (avs_read && !ack_q && widx == `OD_IDX_MASK) |=> avs_readdata == {24'h000000, $past(mask_q)})
      else $error("mask read data wrong");

   c_switch_hit: cover property (!dsrc_s && !aen_s && sw_hit ##1 port_cs != 8'h00);
   c_custom_hit: cover property (dsrc_s && !aen_s && cust_hit != 8'h00 ##1 port_cs != 8'h00);
   c_irq_clear: cover property (irq ##1 wr_status ##1 !irq);
   c_dma_cycle: cover property (aen_s && sw_hit ##1 port_cs == 8'h00);

endmodule : od_decode_top

// ---- testbench/od_host_model.sv ----
module od_host_model (
   // Clock
   input wire logic mclk,
   // Host address bus
   output logic [15:0] host_addr,
   output logic host_aen,
   // Host interrupt lines
   input wire logic [9:0] irq_out,
   input wire logic [9:0] irq_oe,
   input wire logic [1:0] pd_en,
   input wire logic ext_pd,
   output logic [9:0] level,
   output logic pd_clash
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [9:0] float_q = 10'h000;
   logic pd_any;

   // ----------------------------------------
   // Line resolution
   // ----------------------------------------
   // Only one pull-down may sit on a shared line
   assign pd_clash = (pd_en == 2'h3) | ((pd_en != 2'h0) & ext_pd);
   assign pd_any = (|pd_en) | ext_pd;
   // Undriven line with no pull-down wanders
   always @(posedge mclk) begin
      float_q <= ~float_q;
   end
   // Pull-down holds a released line low
   assign level = (irq_oe & irq_out) | (~irq_oe & (pd_any ? 10'h000 : float_q));

   initial begin
      host_addr = 16'h0000;
      host_aen = 1'h1;
   end

   // I/O cycle, held long enough to pass the synchroniser
   task io_cycle(input logic [15:0] a, input logic aen);
      host_addr <= a;
      host_aen <= aen;
      repeat (4) @(posedge mclk);
   endtask : io_cycle
endmodule : od_host_model

// ---- testbench/testbench.sv ----
`define CHK(g, e) check(32'(g), 32'(e))

module testbench;
   timeunit 1ns;
   timeprecision 1ps;

   logic mclk, reset, avs_read, avs_write, dsrc, ext_pd, host_aen, irq, avs_waitrequest;
   logic pd_clash;
   logic [5:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [15:0] host_addr, b;
   logic [6:0] sw_on;
   logic [1:0] mode_lo, mode_hi, pd_en;
   logic [3:0] sel [8];
   logic [7:0] uart_irq, port_cs;
   logic [2:0] port_reg;
   logic [9:0] line_out, line_oe, level;
   logic [6:0] pats [3] = '{7'h75, 7'h29, 7'h7F};
   int n_mismatch = 0;
   int tests_run = 0;

   od_decode_top u_od_decode_top (.mclk(mclk), .reset(reset), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .host_addr(host_addr), .host_aen(host_aen), .base_switch_on(sw_on),
      .decode_source_select(dsrc), .low_group_irq_mode_select(mode_lo),
      .high_group_irq_mode_select(mode_hi), .first_port_irq_selector(sel[0]),
      .second_port_irq_selector(sel[1]), .third_port_irq_selector(sel[2]),
      .fourth_port_irq_selector(sel[3]), .fifth_port_irq_selector(sel[4]),
      .sixth_port_irq_selector(sel[5]), .seventh_port_irq_selector(sel[6]),
      .eighth_port_irq_selector(sel[7]), .ext_pulldown_sense(ext_pd), .uart_irq(uart_irq),
      .port_cs(port_cs), .port_reg(port_reg), .host_irq_out(line_out),
      .host_irq_oe(line_oe), .group_pulldown_en(pd_en), .irq(irq));

   od_host_model u_od_host_model (.mclk(mclk), .host_addr(host_addr), .host_aen(host_aen),
      .irq_out(line_out), .irq_oe(line_oe), .pd_en(pd_en), .ext_pd(ext_pd),
      .level(level), .pd_clash(pd_clash));

   initial begin
      mclk = 1'h0;
      forever #4 mclk = ~mclk;
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task complete_run;
      if (n_mismatch == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : complete_run

   task check(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : check

   task tick(input int n);
      repeat (n) @(posedge mclk);
   endtask : tick

   task bus(input logic wr, input logic [5:0] a, input logic [31:0] wd, output logic [31:0] d);
      int i;
      avs_address <= a;
      avs_writedata <= wd;
      avs_read <= ~wr;
      avs_write <= wr;
      for (i = 0; i < 16; i++) begin
         @(posedge mclk);
         if (avs_waitrequest === 1'h0) break;
      end
      d = avs_readdata;
      avs_read <= 1'h0;
      avs_write <= 1'h0;
      @(posedge mclk);
      if (i == 16) begin
         n_mismatch++;
         complete_run();
      end
   endtask : bus

   task hio(input logic [15:0] a, input logic aen, input logic [7:0] cs, input logic [2:0] r);
      u_od_host_model.io_cycle(a, aen);
      @(negedge mclk);
      `CHK(port_cs, cs);
      if (cs != 8'h00) `CHK(port_reg, r);
      @(posedge mclk);
   endtask : hio

   task settle;
      tick(4);
      @(negedge mclk);
   endtask : settle

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_regs;
      bus(1'h0, 6'h00, 32'h0, rd);
      `CHK(rd, 32'h1);
      bus(1'h0, 6'h08, 32'h0, rd);
      `CHK(rd, 32'h0);
      bus(1'h1, 6'h14, 32'hFFFFFFFF, rd);
      bus(1'h0, 6'h14, 32'h0, rd);
      `CHK(rd, 32'h0);
      bus(1'h0, 6'h24, 32'h0, rd);
      `CHK(rd, 32'h289);
   endtask : t_regs

   task t_switch;
      for (int p = 0; p < 3; p++) begin
         sw_on <= pats[p];
         b = {3'h0, ~pats[p], 6'h00};
         tick(4);
         for (int n = 0; n < 8; n++) hio(b + 16'(8 * n + n), 1'h0, 8'(1 << n), 3'(n));
         hio(b + 16'h003F, 1'h0, 8'h80, 3'h7);
         hio(b + 16'h0040, 1'h0, 8'h00, 3'h0);
         hio(b - 16'h0001, 1'h0, 8'h00, 3'h0);
         hio(b, 1'h1, 8'h00, 3'h0);
         hio({3'h0, pats[p], 6'h00}, 1'h0, 8'h00, 3'h0);
      end
      sw_on <= 7'h75;
      hio(16'h0280, 1'h0, 8'h01, 3'h0);
   endtask : t_switch

   task t_custom;
      dsrc <= 1'h1;
      hio(16'h028B, 1'h0, 8'h02, 3'h3);
      bus(1'h1, 6'h20, 32'h3F9, rd);
      hio(16'h03FA, 1'h0, 8'h01, 3'h2);
      hio(16'h0280, 1'h0, 8'h00, 3'h0);
      bus(1'h1, 6'h3C, 32'h2B8, rd);
      hio(16'h02B8, 1'h0, 8'h00, 3'h0);
      hio(16'h029C, 1'h0, 8'h08, 3'h4);
      dsrc <= 1'h0;
      tick(4);
   endtask : t_custom

   task t_normal;
      sel[0] <= 4'h3;
      sel[4] <= 4'h4;
      mode_hi <= 2'h3;
      uart_irq <= 8'h11;
      settle();
      `CHK(line_oe, 10'h004);
      `CHK(level[2], 1'h1);
      @(posedge mclk);
      bus(1'h0, 6'h04, 32'h0, rd);
      `CHK(rd[7:0], 8'h11);
      `CHK(irq, 1'h0);
      bus(1'h1, 6'h08, 32'h1, rd);
      `CHK(irq, 1'h1);
      uart_irq <= 8'h00;
      settle();
      `CHK(line_oe, 10'h004);
      `CHK(line_out[2], 1'h0);
      @(posedge mclk);
      bus(1'h1, 6'h04, 32'h1, rd);
      `CHK(irq, 1'h0);
      uart_irq <= 8'h01;
      bus(1'h1, 6'h00, 32'h0, rd);
      settle();
      `CHK(line_oe, 10'h000);
      @(posedge mclk);
      bus(1'h1, 6'h00, 32'h1, rd);
      sel[0] <= 4'h0;
      settle();
      `CHK(line_oe, 10'h000);
      @(posedge mclk);
      sel[7] <= 4'hA;
      mode_hi <= 2'h0;
      uart_irq <= 8'h80;
      settle();
      `CHK(line_oe, 10'h208);
      `CHK(level[9], 1'h1);
      @(posedge mclk);
      sel[4] <= 4'h0;
      sel[7] <= 4'h0;
      uart_irq <= 8'h01;
   endtask : t_normal

   task t_shared;
      sel[0] <= 4'h6;
      mode_lo <= 2'h1;
      mode_hi <= 2'h0;
      settle();
      `CHK(line_oe, 10'h000);
      @(posedge mclk);
      ext_pd <= 1'h1;
      settle();
      `CHK(line_oe, 10'h020);
      `CHK(level[5], 1'h1);
      @(posedge mclk);
      uart_irq <= 8'h00;
      settle();
      `CHK(line_oe, 10'h000);
      `CHK(level[5], 1'h0);
      @(posedge mclk);
      ext_pd <= 1'h0;
      mode_lo <= 2'h2;
      uart_irq <= 8'h01;
      settle();
      `CHK(pd_en, 2'h1);
      `CHK(line_oe, 10'h020);
      @(posedge mclk);
      mode_lo <= 2'h1;
      mode_hi <= 2'h2;
      settle();
      `CHK(pd_en, 2'h2);
      `CHK(pd_clash, 1'h0);
      @(posedge mclk);
      bus(1'h0, 6'h0C, 32'h0, rd);
      `CHK(rd, 32'h20000975);
   endtask : t_shared

   initial begin
      reset = 1'h1;
      avs_read = 1'h0;
      avs_write = 1'h0;
      avs_address = 6'h00;
      avs_writedata = 32'h0;
      sw_on = 7'h75;
      dsrc = 1'h0;
      ext_pd = 1'h0;
      mode_lo = 2'h0;
      mode_hi = 2'h0;
      uart_irq = 8'h00;
      for (int i = 0; i < 8; i++) sel[i] = 4'h0;
      tick(6);
      reset <= 1'h0;
      tick(3);
      t_regs();
      t_switch();
      t_custom();
      t_normal();
      t_shared();
      complete_run();
   end
endmodule : testbench
